// file: aof_pkg.sv
// Shared constants and types for the ADC output-format configuration bank.
// Assumes an 8-bit register address, 16-bit register data and four channels.
`default_nettype none
package aof_pkg;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int NCH = 4;
  localparam int WMAX = 18;
  // Register addresses as printed.
  localparam logic [7:0] ADR_GLOBAL_FILT = 8'h29;
  localparam logic [7:0] ADR_CHAN_FILT0 = 8'h2E;
  localparam logic [7:0] ADR_OUT_RATE = 8'h38;
  localparam logic [7:0] ADR_PHASE_REF = 8'h42;
  localparam logic [7:0] ADR_PATTERN = 8'h45;
  localparam logic [7:0] ADR_SERIAL = 8'h46;
  localparam logic [7:0] ADR_LANE_MAP1 = 8'h50;
  localparam logic [7:0] ADR_RESOLUTION = 8'hB3;
  localparam logic [7:0] ADR_EXT_REF_EN = 8'hF0;
  // Field positions.
  localparam int GATE_BIT = 15;
  localparam int FILT_USE_BIT = 0;
  localparam int TAP_BIT = 2;
  localparam int DEC_LSB = 4;
  localparam int SHAPE_LSB = 7;
  localparam int GLOBAL_FILT_BIT = 1;
  localparam int RATE_LSB = 0;
  localparam int PHASE_LSB = 5;
  localparam int EXTREF_BIT = 3;
  localparam int SYNC_BIT = 1;
  localparam int DESKEW_BIT = 0;
  localparam int W18_BIT = 12;
  localparam int W16_BIT = 11;
  localparam int W14_BIT = 10;
  localparam int PAD_BIT = 5;
  localparam int MSB_BIT = 3;
  localparam int SIGNED_BIT = 2;
  localparam int DUAL_BIT = 0;
  localparam int RES_BIT = 0;
  // Writable bits of each register; all other bits read as zero.
  localparam logic [15:0] CHAN_MASK = 16'h03F5;
  localparam logic [15:0] GLOBAL_MASK = 16'h0002;
  localparam logic [15:0] RATE_MASK = 16'h0003;
  localparam logic [15:0] PHREF_MASK = 16'h8068;
  localparam logic [15:0] PHASE_FIELD = 16'h0060;
  localparam logic [15:0] PATTERN_MASK = 16'h0003;
  localparam logic [15:0] SERIAL_MASK = 16'h9C2D;
  localparam logic [15:0] MAP1_MASK = 16'h8FFF;
  localparam logic [15:0] RES_MASK = 16'h8001;
  localparam logic [15:0] EXTREF_MASK = 16'h8000;
  // Reset values.
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] PHREF_RST = 16'h0040;
  localparam logic [1:0] PHASE_DEFAULT = 2'h2;
  // Alignment words.
  localparam logic [15:0] SYNC_WORD = 16'hFF00;
  localparam logic [15:0] DESKEW_WORD = 16'hAAAA;
  // Serialized word lengths.
  localparam logic [4:0] LEN18 = 5'h12;
  localparam logic [4:0] LEN16 = 5'h10;
  localparam logic [4:0] LEN14 = 5'h0E;
  // Decimation codes.
  localparam logic [2:0] DEC_BY2 = 3'h0;
  localparam logic [2:0] DEC_BY4 = 3'h1;
  localparam logic [2:0] DEC_BY8 = 3'h4;
  typedef enum logic [2:0] {
    SHAPE_LP2 = 3'h0,
    SHAPE_HP2 = 3'h1,
    SHAPE_LP4 = 3'h2,
    SHAPE_BP1_4 = 3'h3,
    SHAPE_BP2_4 = 3'h4,
    SHAPE_HP4 = 3'h5
  } aof_shape_t;
  typedef struct packed {
    logic use_filter;
    logic tap_odd;
    logic [2:0] dec;
    logic [2:0] shape;
  } aof_chan_t;
  typedef struct packed {
    logic [4:0] len;
    logic msb_first;
    logic signed_fmt;
    logic dual_lane;
  } aof_ser_t;
endpackage
`default_nettype wire

// file: aof_top.sv
// Configuration bank and output word former of a quad ADC digital back end.
// Assumes converter samples arrive on clk_i and the frame clock arrives from a pin.
// What this block does
// [RULE_01] Channel filter-use bit 0 bypasses the decimation filter, 1 applies it.
// [RULE_02] Tap-parity bit 0 selects even-tap filter, 1 selects odd-tap filter.
// [RULE_03] Decimation field codes 000, 001, 100 mean by 2, 4, 8; others forbidden.
// [RULE_04] Filter-type field selects one of six low, high or band-pass filters.
// [RULE_05] Output-rate code 0..3 gives full, half, quarter or eighth data rate.
// [RULE_06] Phase/reference gate bit makes bits 6, 5 and 3 take effect.
// [RULE_07] Bit-clock phase resets to 10 but reads 00 until first written.
// [RULE_08] Bit-clock phase field sets bit-clock phase against frame clock edge.
// [RULE_09] External reference needs the 0x42 bit and the 0xF0 enable both set.
// [RULE_10] Sync-pattern bit replaces every channel's data with word FF00.
// [RULE_11] Deskew-pattern bit replaces every channel's data with alternating ones and zeros.
// [RULE_12] Wire-mode bit picks one lane or two lanes with half-rate frame clock.
// [RULE_13] Resolution gate bit 0 forbids selecting the low-power 14-bit mode.
// [RULE_14] With gate set, select bit 0 gives 16-bit, 1 gives 14-bit resolution.
// [RULE_15] Channel filter-use works only with global digital-filter enable set.
// [RULE_16] Lane-map codes 0000-0111 pick a byte; top bit set powers the lane down.
// [RULE_17] Gated serializer control picks 14, 16 or 18 bits, optional zero pad.
// [RULE_18] Bit-order bit picks LSB or MSB first; format bit picks offset or signed.
//
// Local design decision: the plain strobed port.
`default_nettype none
module aof_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [aof_pkg::AW-1:0] addr_i,
  input wire logic [aof_pkg::DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [aof_pkg::DW-1:0] rdata_o,
  // Converter samples and frame clock pin.
  input wire logic [aof_pkg::NCH-1:0][15:0] sample_i,
  input wire logic frame_clock_i,
  // Effective configuration.
  output aof_pkg::aof_chan_t [aof_pkg::NCH-1:0] chan_cfg_o,
  output logic [1:0] out_rate_o,
  output logic [1:0] bit_clock_phase_o,
  output logic external_ref_o,
  output logic resolution_14b_o,
  output aof_pkg::aof_ser_t ser_cfg_o,
  output logic lane_map_group1_en_o,
  output logic [11:0] lane_map_field_o,
  output logic [2:0] lane_pd_o,
  // Formed words, one per channel, first bit to send at bit 17.
  output logic [aof_pkg::NCH-1:0][aof_pkg::WMAX-1:0] word_o,
  output logic word_valid_o
);
  import aof_pkg::*;

  // Raw register images; reserved bits are held at zero so reads need no mask.
  logic [NCH-1:0][15:0] chan_q, chan_d;
  logic [15:0] glob_q, glob_d, rate_q, rate_d, phref_q, phref_d, pat_q, pat_d;
  logic [15:0] ser_q, ser_d, map_q, map_d, res_q, res_d, extref_q, extref_d;
  // Set by any write to the phase register; only reset clears it again.
  logic phase_wr_q, phase_wr_d;
  logic [15:0] rdata_q, rdata_d;

  // Register writes and read mux; reserved bits are masked off at write time.
  always_comb begin
    chan_d = chan_q;
    glob_d = glob_q;
    rate_d = rate_q;
    phref_d = phref_q;
    pat_d = pat_q;
    ser_d = ser_q;
    map_d = map_q;
    res_d = res_q;
    extref_d = extref_q;
    phase_wr_d = phase_wr_q;
    rdata_d = ZERO_RST;
    if (we_i) begin
      // Channel filter registers sit at consecutive addresses from the first one.
      for (int c = 0; c < NCH; c++) begin
        if (addr_i == ADR_CHAN_FILT0 + 8'(c)) begin
          chan_d[c] = wdata_i & CHAN_MASK;
        end
      end
      // Writes to unmapped addresses fall through and change nothing.
      unique case (addr_i)
        ADR_GLOBAL_FILT: glob_d = wdata_i & GLOBAL_MASK;
        ADR_OUT_RATE: rate_d = wdata_i & RATE_MASK;
        ADR_PHASE_REF: begin
          phref_d = wdata_i & PHREF_MASK;
          phase_wr_d = 1'b1; // [RULE_07]
        end
        ADR_PATTERN: pat_d = wdata_i & PATTERN_MASK;
        ADR_SERIAL: ser_d = wdata_i & SERIAL_MASK;
        ADR_LANE_MAP1: map_d = wdata_i & MAP1_MASK;
        ADR_RESOLUTION: res_d = wdata_i & RES_MASK;
        ADR_EXT_REF_EN: extref_d = wdata_i & EXTREF_MASK;
        default: ;
      endcase
    end
    // Read data are registered, so they stand only in the cycle after the strobe.
    if (re_i) begin
      for (int c = 0; c < NCH; c++) begin
        if (addr_i == ADR_CHAN_FILT0 + 8'(c)) begin
          rdata_d = chan_q[c];
        end
      end
      unique case (addr_i)
        ADR_GLOBAL_FILT: rdata_d = glob_q;
        ADR_OUT_RATE: rdata_d = rate_q;
        // The phase field hides its default until software first writes it.
        ADR_PHASE_REF: rdata_d = phase_wr_q ? phref_q : (phref_q & ~PHASE_FIELD); // [RULE_07]
        ADR_PATTERN: rdata_d = pat_q;
        ADR_SERIAL: rdata_d = ser_q;
        ADR_LANE_MAP1: rdata_d = map_q;
        ADR_RESOLUTION: rdata_d = res_q;
        ADR_EXT_REF_EN: rdata_d = extref_q;
        default: ;
      endcase
    end
  end

  // Register storage.
  // Only the phase register has a non-zero reset value, its hidden default.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_q <= '0;
      glob_q <= ZERO_RST;
      rate_q <= ZERO_RST;
      phref_q <= PHREF_RST;
      pat_q <= ZERO_RST;
      ser_q <= ZERO_RST;
      map_q <= ZERO_RST;
      res_q <= ZERO_RST;
      extref_q <= ZERO_RST;
      phase_wr_q <= 1'b0;
      rdata_q <= ZERO_RST;
    end else begin
      chan_q <= chan_d;
      glob_q <= glob_d;
      rate_q <= rate_d;
      phref_q <= phref_d;
      pat_q <= pat_d;
      ser_q <= ser_d;
      map_q <= map_d;
      res_q <= res_d;
      extref_q <= extref_d;
      phase_wr_q <= phase_wr_d;
      rdata_q <= rdata_d;
    end
  end

  // Frame clock synchroniser; sync1 feeds only sync2, and a level counts once
  // sync2 and sync3 agree, which filters a single-sample glitch.
  // The pin must idle low out of reset, or its first high level reads as an edge.
  logic sync1_q, sync2_q, sync3_q, frame_lvl_q, frame_lvl_d, frame_rise;
  always_comb begin
    frame_lvl_d = (sync2_q == sync3_q) ? sync2_q : frame_lvl_q;
    frame_rise = sync2_q & sync3_q & ~frame_lvl_q;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      frame_lvl_q <= 1'b0;
    end else begin
      sync1_q <= frame_clock_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      frame_lvl_q <= frame_lvl_d;
    end
  end

  // Effective configuration derived from the raw registers.
  aof_chan_t [NCH-1:0] chan_cfg_d;
  aof_ser_t ser_cfg_d;
  logic [1:0] phase_d;
  logic ext_ref_d, res14_d;
  logic [2:0] lane_pd_d;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // Per-channel enable only counts under the global filter enable.
      chan_cfg_d[c].use_filter = chan_q[c][FILT_USE_BIT] & glob_q[GLOBAL_FILT_BIT]; // [RULE_01] [RULE_15]
      chan_cfg_d[c].tap_odd = chan_q[c][TAP_BIT]; // [RULE_02]
      // Illegal decimation codes pass through unchanged; downstream must not rely on them.
      chan_cfg_d[c].dec = chan_q[c][DEC_LSB +: 3]; // [RULE_03]
      chan_cfg_d[c].shape = chan_q[c][SHAPE_LSB +: 3]; // [RULE_04]
    end
    // With the gate low the phase stays at its default and the reference internal.
    phase_d = phref_q[GATE_BIT] ? phref_q[PHASE_LSB +: 2] : PHASE_DEFAULT; // [RULE_06] [RULE_08]
    // Both enables are needed, so a stray write to either one cannot switch the reference.
    ext_ref_d = phref_q[GATE_BIT] & phref_q[EXTREF_BIT] & extref_q[GATE_BIT]; // [RULE_06] [RULE_09]
    res14_d = res_q[GATE_BIT] & res_q[RES_BIT]; // [RULE_13] [RULE_14]
    // Serializer width; when several widths are set the widest wins.
    ser_cfg_d.len = res14_d ? LEN14 : LEN16;
    if (ser_q[GATE_BIT]) begin
      if (ser_q[W18_BIT]) begin
        ser_cfg_d.len = LEN18; // [RULE_17]
      end else if (ser_q[W16_BIT]) begin
        ser_cfg_d.len = LEN16; // [RULE_17]
      end else if (ser_q[W14_BIT]) begin
        ser_cfg_d.len = ser_q[PAD_BIT] ? LEN16 : LEN14; // [RULE_17]
      end
    end
    // Format bits count only under the serializer gate, like the width bits.
    ser_cfg_d.msb_first = ser_q[GATE_BIT] & ser_q[MSB_BIT]; // [RULE_18]
    ser_cfg_d.signed_fmt = ser_q[GATE_BIT] & ser_q[SIGNED_BIT]; // [RULE_18]
    ser_cfg_d.dual_lane = ser_q[GATE_BIT] & ser_q[DUAL_BIT]; // [RULE_12]
    // A lane buffer powers down only while the first mapping group is enabled.
    for (int l = 0; l < 3; l++) begin
      lane_pd_d[l] = map_q[GATE_BIT] & map_q[4*l+3]; // [RULE_16]
    end
  end

  // Output word forming on each frame edge that the output rate keeps.
  // The rate counter free-runs on frame edges, so after a rate change the first kept
  // edge depends on where it stood; software cannot choose which edge is kept.
  logic [2:0] rate_cnt_q, rate_cnt_d;
  logic [2:0] keep_mask;
  logic take;
  logic [NCH-1:0][WMAX-1:0] word_d;
  logic [15:0] raw;
  logic [WMAX-1:0] w;
  logic [WMAX-1:0] rev;
  always_comb begin
    raw = '0;
    w = '0;
    rev = '0;
    // Rate code n keeps one frame edge in every two to the power n.
    unique case (rate_q[RATE_LSB +: 2])
      2'h0: keep_mask = 3'h0; // [RULE_05]
      2'h1: keep_mask = 3'h1; // [RULE_05]
      2'h2: keep_mask = 3'h3; // [RULE_05]
      2'h3: keep_mask = 3'h7; // [RULE_05]
    endcase
    take = frame_rise & ((rate_cnt_q & keep_mask) == 3'h0);
    rate_cnt_d = frame_rise ? rate_cnt_q + 3'h1 : rate_cnt_q;
    word_d = word_o;
    for (int c = 0; c < NCH; c++) begin
      // Sync outranks deskew when both are set.
      if (pat_q[SYNC_BIT]) begin
        raw = SYNC_WORD; // [RULE_10]
      end else if (pat_q[DESKEW_BIT]) begin
        raw = DESKEW_WORD; // [RULE_11]
      end else begin
        raw = sample_i[c];
      end
      // Samples are left-aligned offset binary; flip the top bit for signed output.
      // Patterns skip the flip so the receiver always sees the fixed alignment words.
      if (ser_cfg_d.signed_fmt && !pat_q[SYNC_BIT] && !pat_q[DESKEW_BIT]) begin
        raw[15] = ~raw[15]; // [RULE_18]
      end
      // Left-justify in the 18-bit field; the 14-bit case drops two low bits.
      w = {raw, 2'h0};
      if (ser_cfg_d.len == LEN14 || (ser_cfg_d.len == LEN16 && ser_q[GATE_BIT]
          && !ser_q[W18_BIT] && !ser_q[W16_BIT] && ser_q[W14_BIT])) begin
        w = {raw[15:2], 4'h0}; // [RULE_17]
      end
      // LSB first: reverse the active bits and keep them left-justified.
      for (int b = 0; b < WMAX; b++) begin
        rev[b] = w[WMAX-1-b];
      end
      rev = rev << (5'(WMAX) - ser_cfg_d.len);
      if (take) begin
        word_d[c] = ser_cfg_d.msb_first ? w : rev; // [RULE_18]
      end
    end
  end

  // Output registers; every top-level output comes from here or the register bank.
  // Registering every output costs a cycle of lag but keeps the outputs glitch free.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_cnt_q <= 3'h0;
      word_o <= '0;
      word_valid_o <= 1'b0;
      chan_cfg_o <= '0;
      out_rate_o <= 2'h0;
      bit_clock_phase_o <= PHASE_DEFAULT;
      external_ref_o <= 1'b0;
      resolution_14b_o <= 1'b0;
      ser_cfg_o <= '{len: LEN16, default: 1'b0};
      lane_map_group1_en_o <= 1'b0;
      lane_map_field_o <= 12'h000;
      lane_pd_o <= 3'h0;
    end else begin
      rate_cnt_q <= rate_cnt_d;
      word_o <= word_d;
      word_valid_o <= take;
      chan_cfg_o <= chan_cfg_d;
      out_rate_o <= rate_q[RATE_LSB +: 2];
      bit_clock_phase_o <= phase_d;
      external_ref_o <= ext_ref_d;
      resolution_14b_o <= res14_d;
      ser_cfg_o <= ser_cfg_d;
      lane_map_group1_en_o <= map_q[GATE_BIT];
      lane_map_field_o <= map_q[11:0];
      lane_pd_o <= lane_pd_d;
    end
  end

  // Read data leave straight from their register.
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// file: placeholder_end.sv
// Intentionally empty compilation unit.
`default_nettype none
`default_nettype wire

// file: aof_rx.sv
// Far-side model: frame clock source and word capture of the link receiver.
// Assumes the bench raises run_i to let frames flow; the clock stands low otherwise.
`default_nettype none
module aof_rx (
  // Clock and control.
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  // Formed words from the block.
  input wire logic [aof_pkg::NCH-1:0][aof_pkg::WMAX-1:0] word_i,
  input wire logic valid_i,
  // Frame clock and capture results.
  output logic frame_clock_o,
  output logic [15:0] edges_o,
  output logic [15:0] cnt_o,
  output logic [aof_pkg::WMAX-1:0] last_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import aof_pkg::*;
  // The 3 ns offset keeps frame edges off the block clock grid; 160 ns period.
  initial begin
    frame_clock_o = 1'b0;
    edges_o = 16'h0000;
    #3;
    forever begin
      #80;
      frame_clock_o = run_i & ~frame_clock_o;
      if (frame_clock_o) edges_o = edges_o + 16'h0001;
    end
  end
  // One capture per kept edge; the receiver takes whatever lane mode is set.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_o <= 16'h0000;
      last_o <= '0;
    end else if (valid_i) begin
      cnt_o <= cnt_o + 16'h0001;
      last_o <= word_i[0];
    end
  end
endmodule
`default_nettype wire

// file: aof_top_assertions.sv
// Checker for the output-format bank, watching only the top module's ports.
// Assumes one clock domain and that software leaves patterns alone during frames.
`default_nettype none
module aof_top_assertions (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [aof_pkg::AW-1:0] addr_i,
  input wire logic [aof_pkg::DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [aof_pkg::DW-1:0] rdata_o,
  // Effective configuration and words.
  input wire logic [1:0] out_rate_o,
  input wire logic [1:0] bit_clock_phase_o,
  input wire logic resolution_14b_o,
  input wire aof_pkg::aof_ser_t ser_cfg_o,
  input wire logic [aof_pkg::NCH-1:0][aof_pkg::WMAX-1:0] word_o,
  input wire logic word_valid_o
);
  import aof_pkg::*;
  logic [1:0] pat_q, pat_d;
  logic [2:0] age_q, age_d;
  logic pad14_q, pad14_d;
  // Pattern shadow; the age keeps word checks clear of a fresh pattern write.
  always_comb begin
    pat_d = pat_q;
    age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    pad14_d = pad14_q;
    if (we_i && addr_i == ADR_PATTERN) begin
      pat_d = wdata_i[1:0];
      age_d = 3'h0;
    end
    // The gated 14-bit form drops two data bits even when padding keeps length 16.
    if (we_i && addr_i == ADR_SERIAL) begin
      pad14_d = wdata_i[15] & wdata_i[10] & !wdata_i[11] & !wdata_i[12];
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pat_q <= 2'h0;
      age_q <= 3'h0;
      pad14_q <= 1'b0;
    end else begin
      pat_q <= pat_d;
      age_q <= age_d;
      pad14_q <= pad14_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr(logic [7:0] a, logic g);
    we_i && addr_i == a && g;
  endsequence
  sequence s_kept(logic [1:0] p);
    word_valid_o && age_q == 3'h7 && pat_q == p && !pad14_q && ser_cfg_o.msb_first &&
      ser_cfg_o.len == LEN16;
  endsequence
  a_read_idle: assert property (!$past(re_i) |-> rdata_o == ZERO_RST)
    else $error("read data not zero outside the answer cycle");
  a_rate_follow: assert property (s_wr(ADR_OUT_RATE, 1'b1) |-> ##2
    {14'h0, out_rate_o} == ($past(wdata_i, 2) & RATE_MASK)) else $error("rate code mismatch");
  a_phase_on: assert property (s_wr(ADR_PHASE_REF, wdata_i[15]) |-> ##2
    {9'h0, bit_clock_phase_o, 5'h00} == ($past(wdata_i, 2) & PHASE_FIELD))
    else $error("gated phase not applied");
  a_phase_off: assert property (s_wr(ADR_PHASE_REF, !wdata_i[15]) |-> ##2
    bit_clock_phase_o == PHASE_DEFAULT) else $error("phase changed with gate off");
  a_res_gate: assert property (s_wr(ADR_RESOLUTION, !wdata_i[15]) |-> ##2
    !resolution_14b_o) else $error("low-power mode taken with gate off");
  a_res_sel: assert property (s_wr(ADR_RESOLUTION, wdata_i[15]) |-> ##2
    resolution_14b_o == (($past(wdata_i, 2) & RES_MASK) == 16'h8001))
    else $error("resolution select mismatch");
  a_len_wide: assert property (s_wr(ADR_SERIAL, wdata_i[15] && wdata_i[12]) |-> ##2
    ser_cfg_o.len == LEN18) else $error("wide word length not taken");
  a_ser_fields: assert property (s_wr(ADR_SERIAL, wdata_i[15]) |-> ##2
    {12'h0, ser_cfg_o.msb_first, ser_cfg_o.signed_fmt, 1'b0, ser_cfg_o.dual_lane} ==
    ($past(wdata_i, 2) & 16'h000D)) else $error("serializer fields mismatch");
  a_sync_word: assert property (s_kept(2'h2) |->
    word_o[0][17:2] == SYNC_WORD && word_o[3][17:2] == SYNC_WORD) else $error("sync word wrong");
  a_deskew_word: assert property (s_kept(2'h1) |->
    word_o[1][17:2] == DESKEW_WORD) else $error("deskew word wrong");
  a_pad_zero: assert property (word_valid_o && pad14_q && ser_cfg_o.msb_first |->
    word_o[0][3:0] == 4'h0 && word_o[3][3:0] == 4'h0) else $error("14-bit word low bits not zero");
  a_valid_pulse: assert property (word_valid_o |=> !word_valid_o)
    else $error("word valid longer than one cycle");
endmodule
bind aof_top aof_top_assertions aof_top_assertions_i (.clk_i, .rstn_i, .addr_i, .wdata_i,
  .we_i, .re_i, .rdata_o, .out_rate_o, .bit_clock_phase_o, .resolution_14b_o, .ser_cfg_o,
  .word_o, .word_valid_o);
`default_nettype wire

// file: aof_top_tb.sv
// Self-checking bench for the output-format bank with a frame clock partner.
// Assumes the design lags its registers by two edges and forms one word per kept edge.
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module aof_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import aof_pkg::*;
  logic clk_i, rstn_i, we_i, re_i, run, frame_clock_i, lane_map_group1_en_o, word_valid_o;
  logic external_ref_o, resolution_14b_o, u, t, gl;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, v, d, c0, edges, cnt;
  logic [NCH-1:0][15:0] sample_i;
  logic [1:0] out_rate_o, bit_clock_phase_o;
  logic [2:0] lane_pd_o;
  logic [11:0] lane_map_field_o;
  logic [17:0] last;
  logic [NCH-1:0][WMAX-1:0] word_o;
  aof_chan_t [NCH-1:0] chan_cfg_o;
  aof_chan_t ec;
  aof_ser_t ser_cfg_o;
  int err_count, num_checks;
  logic [2:0] decs [3] = '{DEC_BY2, DEC_BY4, DEC_BY8};
  logic [15:0] sers [8] = '{16'h8808, 16'h9008, 16'h8408, 16'h8428, 16'h8800, 16'h880C,
    16'h8809, 16'h1C2D};
  aof_top aof_top_i (.clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .sample_i,
    .frame_clock_i, .chan_cfg_o, .out_rate_o, .bit_clock_phase_o, .external_ref_o,
    .resolution_14b_o, .ser_cfg_o, .lane_map_group1_en_o, .lane_map_field_o, .lane_pd_o,
    .word_o, .word_valid_o);
  aof_rx aof_rx_i (.clk_i, .rstn_i, .run_i(run), .word_i(word_o), .valid_i(word_valid_o),
    .frame_clock_o(frame_clock_i), .edges_o(edges), .cnt_o(cnt), .last_o(last));
  // Free-running 50 MHz block clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= dat;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] dat);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    dat = rdata_o;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Lets exactly n frame edges through, then waits for the last word to settle.
  task automatic frames(input int n);
    int e0;
    e0 = edges;
    run <= 1'b1;
    for (int i = 0; i < 4000 && edges < e0 + n; i++) @(posedge clk_i);
    if (edges < e0 + n) begin
      err_count++;
      conclude();
    end else begin
      run <= 1'b0;
      idle(12);
    end
  endtask
  // Expected formed word: pattern or sample, width, padding, sign and bit order.
  function automatic logic [17:0] exp_word(logic [15:0] s, logic [15:0] sr, logic r14,
    logic [1:0] p);
    logic [17:0] w, r;
    logic [15:0] x;
    logic g, w14;
    int len;
    g = sr[15];
    w14 = g & sr[10] & !sr[11] & !sr[12];
    len = (g & sr[12]) ? 18 : (g & sr[11]) ? 16 : w14 ? (sr[5] ? 16 : 14) : (r14 ? 14 : 16);
    x = p[1] ? SYNC_WORD : p[0] ? DESKEW_WORD : s ^ {g & sr[2], 15'h0000};
    w = (len == 14 || w14) ? {x[15:2], 4'h0} : {x, 2'h0};
    r = w;
    if (!(g & sr[3])) for (int i = 0; i < len; i++) r[17 - i] = w[18 - len + i];
    return r;
  endfunction
  initial begin
    {rstn_i, we_i, re_i, run, addr_i, wdata_i, sample_i} = '0;
    err_count = 0;
    num_checks = 0;
    void'($urandom(25));
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ADR_PHASE_REF, v);
    `CHK(v, ZERO_RST)
    `CHK(bit_clock_phase_o, PHASE_DEFAULT)
    wr(ADR_PHASE_REF, 16'h8028);
    rd(ADR_PHASE_REF, v);
    `CHK(v, 16'h8028)
    `CHK({bit_clock_phase_o, external_ref_o}, 3'h2)
    wr(ADR_EXT_REF_EN, EXTREF_MASK);
    idle(2);
    `CHK(external_ref_o, 1'b1)
    wr(ADR_PHASE_REF, 16'h0028);
    idle(2);
    `CHK({bit_clock_phase_o, external_ref_o}, 3'h4)
    wr(8'h77, 16'hFFFF);
    rd(8'h77, v);
    `CHK(v, ZERO_RST)
    wr(ADR_OUT_RATE, 16'hFFFF);
    rd(ADR_OUT_RATE, v);
    `CHK(v, RATE_MASK)
    // Every filter shape once, legal decimation codes only, global gate at random.
    for (int i = 0; i < 6; i++) begin
      u = 1'($urandom);
      t = 1'($urandom);
      gl = 1'($urandom);
      wr(ADR_GLOBAL_FILT, {14'h0, gl, 1'b0});
      wr(ADR_CHAN_FILT0 + 8'(i % 4), {6'h0, 3'(i), decs[i % 3], 1'b0, t, 1'b0, u});
      idle(2);
      ec = '{use_filter: u & gl, tap_odd: t, dec: decs[i % 3], shape: 3'(i)};
      `CHK(chan_cfg_o[i % 4], ec)
    end
    // Each rate code over exactly eight frame edges.
    for (int r = 0; r < 4; r++) begin
      wr(ADR_OUT_RATE, 16'(r));
      idle(2);
      `CHK(out_rate_o, 2'(r))
      c0 = cnt;
      frames(8);
      `CHK(cnt - c0, 16'(8 >> r))
    end
    // Eight serializer formats under data, sync, deskew and both patterns.
    // Full rate first, so the single frame edge of each case is always kept.
    wr(ADR_OUT_RATE, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(ADR_SERIAL, sers[i]);
      wr(ADR_RESOLUTION, (i == 7) ? 16'h8001 : 16'h0000);
      for (int p = 0; p < 4; p++) begin
        wr(ADR_PATTERN, 16'(p));
        sample_i <= {$urandom, $urandom};
        frames(1);
        `CHK(last, exp_word(sample_i[0], sers[i], i == 7, 2'(p)))
        `CHK(word_o[3], exp_word(sample_i[3], sers[i], i == 7, 2'(p)))
      end
      `CHK(ser_cfg_o.dual_lane, sers[i][15] & sers[i][0])
    end
    `CHK(resolution_14b_o, 1'b1)
    wr(ADR_RESOLUTION, 16'h0001);
    idle(2);
    `CHK(resolution_14b_o, 1'b0)
    // Random lane maps; the top code bit powers a lane down only with the enable.
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom) & MAP1_MASK;
      d[15] = 1'(i);
      wr(ADR_LANE_MAP1, d);
      idle(2);
      v = {d[15], d[11:0], {d[11], d[7], d[3]} & {3{d[15]}}};
      `CHK({lane_map_group1_en_o, lane_map_field_o, lane_pd_o}, v)
    end
    conclude();
  end
endmodule
`default_nettype wire
